/* File: asr_pkg.sv */
// Shared constants for the asynchronous static memory host controller
`default_nettype none
package asr_pkg;
  // ==========================================================
  // Geometry
  localparam int ADDR_W        = 10;
  localparam int DATA_W        = 4;
  localparam int WORDS         = 1024;

  // ==========================================================
  // Clock and pin timing, slowest speed grade
  localparam int CLK_PERIOD_NS = 5;
  localparam int ACCESS_NS     = 300;
  localparam int OTD_NS        = 125;
  localparam int AW_NS         = 50;
  localparam int W_NS          = 200;
  localparam int DH_NS         = 30;
  localparam int WR_NS         = 50;
  localparam int DESELECT_TO_RETENTION_TIME_NS = 300;
  localparam int RETENTION_RECOVERY_TIME_NS    = 300;
  localparam int SYNC_CYC      = 3;

  // Least times round up to whole cycles
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OTD_CYC    = (OTD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AW_CYC     = (AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int W_CYC      = (W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DH_CYC     = (DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC     = (WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CDR_CYC    = (DESELECT_TO_RETENTION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCV_CYC    = (RETENTION_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W      = 7;

  // ==========================================================
  // Reset values of the pin drivers
  localparam logic RST_CS_N = 1'b1;
  localparam logic RST_WE_N = 1'b1;

  typedef enum {
    ST_IDLE, ST_RD_WAIT, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD, ST_TURN,
    ST_RET_ENTRY, ST_RET_HOLD, ST_RET_EXIT
  } asr_state_t;
endpackage
`default_nettype wire

/* File: asr_pin_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs
`default_nettype none
module asr_pin_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinStable
);
  logic [W-1:0] s1_q, s2_q, s3_q, stable_q, stable_d;

  // Update only once the second and third stages agree
  always_comb begin
    stable_d = (s2_q == s3_q) ? s3_q : stable_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      stable_q <= '0;
    end else begin
      s1_q     <= pinIn;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      stable_q <= stable_d;
    end
  end

  assign pinStable = stable_q;
endmodule
`default_nettype wire

/* File: asr_host_ctrl.sv */
// Host-side controller for a 1024 x 4 asynchronous static memory
`default_nettype none
// Operation
// - Shared data pins; host drives them only while memory cannot drive.
// - Host holds write-enable high throughout a read cycle.
// - Deselect at least 300 ns before lowering supply to retention.
// - After supply returns, stay deselected 300 ns before accessing.
module asr_host_ctrl
  import asr_pkg::*;
#(
  parameter int AW = asr_pkg::ADDR_W,
  parameter int DW = asr_pkg::DATA_W
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          reqValid,
  input  wire logic          reqWrite,
  input  wire logic [AW-1:0] reqAddr,
  input  wire logic [DW-1:0] reqData,
  output logic               reqReady,
  output logic               rspValid,
  output logic      [DW-1:0] rspData,
  input  wire logic          retentionReq,
  output logic               retentionReady,
  output logic               ramCsN,
  output logic               ramWeN,
  output logic      [AW-1:0] ramAddr,
  output logic      [DW-1:0] ramDataOut,
  output logic               ramDataOe,
  input  wire logic [DW-1:0] ramDataIn
);
  import asr_pkg::*;

  // ==========================================================
  // Read data pins pass the synchroniser
  logic [DW-1:0] pinData;

  asr_pin_sync #(
    .W (DW)
  ) u_sync (
    .clk       (clk),
    .rst       (rst),
    .pinIn     (ramDataIn),
    .pinStable (pinData)
  );

  // ==========================================================
  // Sequencer
  asr_state_t    state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic          csN_q, csN_d;
  logic          weN_q, weN_d;
  logic          oe_q, oe_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d;
  logic [DW-1:0] rdata_q, rdata_d;
  logic          rsp_q, rsp_d;
  logic          cntDone;

  assign cntDone = (cnt_q == '0);

  always_comb begin
    state_d = state_q;
    cnt_d   = cntDone ? cnt_q : cnt_q - 1'b1;
    csN_d   = csN_q;
    weN_d   = weN_q;
    oe_d    = oe_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rsp_d   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (retentionReq) begin
          csN_d   = 1'b1;
          cnt_d   = CNT_W'(CDR_CYC - 1);
          state_d = ST_RET_ENTRY;
        end else if (reqValid) begin
          addr_d = reqAddr;
          if (reqWrite) begin
            wdata_d = reqData;
            cnt_d   = CNT_W'(AW_CYC - 1);
            state_d = ST_WR_SETUP;
          end else begin
            csN_d   = 1'b0;
            weN_d   = 1'b1;
            cnt_d   = CNT_W'(ACCESS_CYC + SYNC_CYC - 1);
            state_d = ST_RD_WAIT;
          end
        end
      end
      ST_RD_WAIT: begin
        if (cntDone) begin
          rdata_d = pinData;
          rsp_d   = 1'b1;
          csN_d   = 1'b1;
          cnt_d   = CNT_W'(OTD_CYC - 1);
          state_d = ST_TURN;
        end
      end
      ST_WR_SETUP: begin
        // Select and strobe fall together, so the memory never drives into us
        if (cntDone) begin
          csN_d   = 1'b0;
          weN_d   = 1'b0;
          oe_d    = 1'b1;
          cnt_d   = CNT_W'(W_CYC - 1);
          state_d = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE: begin
        if (cntDone) begin
          csN_d   = 1'b1;
          weN_d   = 1'b1;
          cnt_d   = CNT_W'(DH_CYC - 1);
          state_d = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        if (cntDone) begin
          oe_d    = 1'b0;
          cnt_d   = CNT_W'(WR_CYC - 1);
          state_d = ST_TURN;
        end
      end
      ST_TURN: begin
        if (cntDone) begin
          state_d = ST_IDLE;
        end
      end
      ST_RET_ENTRY: begin
        if (cntDone) begin
          state_d = ST_RET_HOLD;
        end
      end
      ST_RET_HOLD: begin
        // Contents need no refresh; just stay deselected
        if (!retentionReq) begin
          cnt_d   = CNT_W'(RCV_CYC - 1);
          state_d = ST_RET_EXIT;
        end
      end
      ST_RET_EXIT: begin
        if (cntDone) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        csN_d   = 1'b1;
        weN_d   = 1'b1;
        oe_d    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      csN_q   <= RST_CS_N;
      weN_q   <= RST_WE_N;
      oe_q    <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      rsp_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      csN_q   <= csN_d;
      weN_q   <= weN_d;
      oe_q    <= oe_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rsp_q   <= rsp_d;
    end
  end

  assign reqReady       = (state_q == ST_IDLE) && !retentionReq;
  assign rspValid       = rsp_q;
  assign rspData        = rdata_q;
  assign retentionReady = (state_q == ST_RET_HOLD);
  assign ramCsN         = csN_q;
  assign ramWeN         = weN_q;
  assign ramAddr        = addr_q;
  assign ramDataOut     = wdata_q;
  assign ramDataOe      = oe_q;

  // ==========================================================
  // Checks
  logic [CNT_W-1:0] deselCnt_q, deselCnt_d;
  logic [CNT_W-1:0] rcvCnt_q, rcvCnt_d;
  localparam logic [CNT_W-1:0] CNT_SAT = '1;

  always_comb begin
    deselCnt_d = !csN_q ? '0 : (deselCnt_q == CNT_SAT ? deselCnt_q : deselCnt_q + 1'b1);
    rcvCnt_d   = retentionReady ? '0 : (rcvCnt_q == CNT_SAT ? rcvCnt_q : rcvCnt_q + 1'b1);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deselCnt_q <= '0;
      rcvCnt_q   <= CNT_SAT;
    end else begin
      deselCnt_q <= deselCnt_d;
      rcvCnt_q   <= rcvCnt_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_strobeLow;
    !ramWeN && !ramCsN && ramDataOe;
  endsequence
  sequence s_strobeRelease;
    ramWeN && ramCsN && ramDataOe;
  endsequence

  a_no_contention: assert property (ramDataOe |-> !(!ramCsN && ramWeN))
    else $error("data driven while memory may drive");
  a_read_we_high: assert property ($fell(ramCsN) && ramWeN |-> ramWeN [*8])
    else $error("write enable dropped during read");
  a_write_width: assert property ($fell(ramWeN) |-> s_strobeLow [*8] ##32 s_strobeLow ##1 s_strobeRelease)
    else $error("write strobe width wrong");
  a_write_hold: assert property ($rose(ramWeN) |-> s_strobeRelease [*6] ##1 !ramDataOe)
    else $error("write data hold wrong");
  a_addr_stable: assert property (!ramCsN && !$past(ramCsN) |-> $stable(ramAddr))
    else $error("address moved during access");
  a_desel_we: assert property (ramCsN && !ramDataOe |-> ramWeN)
    else $error("strobe low while deselected");
  a_read_answer: assert property ($fell(ramCsN) && ramWeN |-> ##63 rspValid ##1 ramCsN)
    else $error("read answer timing wrong");
  a_ret_entry: assert property ($rose(retentionReady) |-> deselCnt_q >= CNT_W'(CDR_CYC))
    else $error("retention entered too early");
  a_ret_exit: assert property ($fell(ramCsN) |-> rcvCnt_q >= CNT_W'(RCV_CYC))
    else $error("access too soon after retention");
endmodule
`default_nettype wire

/* File: asr_mem_model.sv */
// Behavioural model of the 1024 x 4 asynchronous static memory
`default_nettype none
module asr_mem_model
  import asr_pkg::*;
(
  input  wire logic                       csN,
  input  wire logic                       weN,
  input  wire logic [asr_pkg::ADDR_W-1:0] addr,
  input  wire logic [asr_pkg::DATA_W-1:0] dataIn,
  output logic      [asr_pkg::DATA_W-1:0] dataOut,
  output logic                            dataOe
);
  timeunit 1ns;
  timeprecision 100ps;
  import asr_pkg::*;
  // ==========================================================
  // Storage, static: no refresh, no clock
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] lastQ;

  assign dataOe = !csN && weN;

  always_latch begin
    if (dataOe) begin
      lastQ = mem[addr];
    end
  end

  // Released pins show the inverse so a stale read cannot pass
  assign dataOut = dataOe ? mem[addr] : ~lastQ;

  always @(csN or weN or addr or dataIn) begin
    if (!csN && !weN) begin
      mem[addr] = dataIn;
    end
  end
endmodule
`default_nettype wire

/* File: asr_host_ctrl_test.sv */
// Self-checking bench for the static memory host controller
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin badCount++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module asr_host_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  import asr_pkg::*;
  logic              clk, rst, reqValid, reqWrite, reqReady, rspValid, retentionReq, retentionReady;
  logic              ramCsN, ramWeN, ramDataOe, memOe;
  logic [ADDR_W-1:0] reqAddr, ramAddr;
  logic [DATA_W-1:0] reqData, rspData, ramDataOut, memOut;
  wire  [DATA_W-1:0] pinLevel;
  int                badCount = 0;
  int                compares = 0;

  // ==========================================================
  // Devices and the shared data pins
  assign pinLevel = (ramDataOe && !memOe) ? ramDataOut : memOut;
  asr_host_ctrl asr_host_ctrl_i (.clk(clk), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .retentionReq(retentionReq), .retentionReady(retentionReady), .ramCsN(ramCsN), .ramWeN(ramWeN),
    .ramAddr(ramAddr), .ramDataOut(ramDataOut), .ramDataOe(ramDataOe), .ramDataIn(pinLevel));
  asr_mem_model asr_mem_model_i (.csN(ramCsN), .weN(ramWeN), .addr(ramAddr), .dataIn(pinLevel),
    .dataOut(memOut), .dataOe(memOe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // Request helpers
  task automatic takeReq(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300) badCount++;
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr  <= a;
    reqData  <= d;
    @(posedge clk);
    reqValid <= 1'b0;
  endtask

  task automatic writeWord(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int weLow, clash;
    weLow = 0;
    clash = 0;
    takeReq(1'b1, a, d);
    repeat (70) begin
      #1;
      if (ramWeN === 1'b0) weLow++;
      if (ramDataOe !== 1'b0 && memOe) clash++;
      @(posedge clk);
    end
    `CHK("write strobe cycles", W_CYC, weLow)
    `CHK("write pin clash", 0, clash)
  endtask

  task automatic readWord(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
    int weHigh, hits, at;
    weHigh = 0;
    hits = 0;
    at = 0;
    takeReq(1'b0, a, 4'h0);
    // The answer stands one cycle, so note where it was seen
    for (int k = 1; k <= 64; k++) begin
      @(posedge clk);
      #1;
      if (ramWeN === 1'b1) weHigh++;
      if (rspValid === 1'b1) begin
        hits++;
        at = k;
      end
    end
    `CHK("read answer cycle", ACCESS_CYC + SYNC_CYC, at)
    `CHK("read data", ex, rspData)
    `CHK("read answer count", 1, hits)
    `CHK("read strobe high", 64, weHigh)
    `CHK("read pin clash", 1'b0, ramDataOe)
  endtask

  // ==========================================================
  // Scenarios
  task automatic testReset;
    `CHK("reset select", 1'b1, ramCsN)
    `CHK("reset strobe", 1'b1, ramWeN)
    `CHK("reset pin drive", 1'b0, ramDataOe)
    `CHK("reset ready", 1'b1, reqReady)
    $display("test reset done");
  endtask

  // Corners and alternating-bit patterns of the address range, back to back
  task automatic testWordCorners;
    logic [ADDR_W-1:0] ad [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
    logic [DATA_W-1:0] dt [4] = '{4'h5, 4'ha, 4'hf, 4'h0};
    for (int i = 0; i < 4; i++) writeWord(ad[i], dt[i]);
    for (int i = 0; i < 4; i++) readWord(ad[i], dt[i]);
    writeWord(10'h3ff, 4'h6);
    readWord(10'h3ff, 4'h6);
    readWord(10'h000, 4'h5);
    $display("test word corners done");
  endtask

  task automatic testRetention;
    int n, selected;
    n = 0;
    selected = 0;
    // Only an idle controller takes the request at once
    while (reqReady !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    @(posedge clk);
    retentionReq <= 1'b1;
    while (retentionReady !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
      if (ramCsN !== 1'b1) selected++;
    end
    `CHK("entry cycles", CDR_CYC + 1, n)
    repeat (30) @(posedge clk);
    retentionReq <= 1'b0;
    n = 0;
    while (reqReady !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
      if (ramCsN !== 1'b1) selected++;
      if (n == 1) `CHK("exit ready drop", 1'b0, retentionReady)
    end
    `CHK("recovery cycles", RCV_CYC + 1, n)
    `CHK("selected in retention", 0, selected)
    readWord(10'h155, 4'hf);
    $display("test retention done");
  endtask

  // ==========================================================
  // Verdict
  task automatic closeOut;
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #60000;
    badCount++;
    closeOut();
  end

  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = '0;
    reqData = '0;
    retentionReq = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    testReset();
    testWordCorners();
    testRetention();
    closeOut();
  end
endmodule
`undef CHK
`default_nettype wire
